//--- inc/iobe_pkg.sv
// Shared types and constants for the increment, inclusive-OR and jump execution block.
package iobe_pkg;

  // ==========================================================================
  // Widths and field positions
  // ==========================================================================
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int LIT_W       = 11;
  localparam int PC_W        = 13;
  localparam int LATCH_HI    = 4;
  localparam int LATCH_LO    = 3;
  localparam int PC_LIT_HI   = 10;

  // ==========================================================================
  // Encodings, steps and reset values
  // ==========================================================================
  localparam logic            DEST_W     = 1'h0;
  localparam logic            DEST_F     = 1'h1;
  localparam logic [7:0]      INC_STEP   = 8'h01;
  localparam logic [7:0]      DATA_ZERO  = 8'h00;
  localparam logic [12:0]     PC_STEP    = 13'h0001;
  localparam logic [12:0]     PC_RESET   = 13'h0000;
  localparam logic [7:0]      W_RESET    = 8'h00;
  localparam logic            ZERO_RESET = 1'h0;
  localparam logic [1:0]      SYNC_RESET = 2'h0;
  localparam logic [1:0]      SYNC_FILL  = 2'h1;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    IOBE_OP_NONE,
    IOBE_OP_INC_SKIP,
    IOBE_OP_INC,
    IOBE_OP_JUMP,
    IOBE_OP_OR_LIT,
    IOBE_OP_OR_FILE
  } iobe_op_t;

  typedef enum logic [0:0] {
    IOBE_EXEC,
    IOBE_FLUSH
  } iobe_phase_t;

  typedef struct packed {
    logic                valid;
    iobe_op_t            op;
    logic [ADDR_W-1:0]   file_addr;
    logic                dest;
    logic [LIT_W-1:0]    literal;
  } iobe_instr_t;

  typedef struct packed {
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } iobe_file_wr_t;

  typedef struct packed {
    iobe_phase_t         phase;
    logic                skip_adv;
    logic [DATA_W-1:0]   w;
    logic                zero;
    logic [PC_W-1:0]     pc;
    iobe_file_wr_t       file_wr;
  } iobe_state_t;

endpackage : iobe_pkg

//--- rtl/iobe_alu.sv
// Result and zero detection for the increment and inclusive-OR operations.
`timescale 1ns/1ns
module iobe_alu
  import iobe_pkg::*;
(
  // Operation select
  input  wire iobe_op_t          op,
  // Operands
  input  wire logic [DATA_W-1:0] w_val,
  input  wire logic [DATA_W-1:0] f_val,
  input  wire logic [DATA_W-1:0] lit_val,
  // Result
  output logic      [DATA_W-1:0] result,
  output logic                   zero
);

  // ==========================================================================
  // Datapath
  // ==========================================================================
  always_comb begin
    case (op)
      IOBE_OP_INC_SKIP,
      IOBE_OP_INC:     result = f_val + INC_STEP;
      IOBE_OP_OR_LIT:  result = w_val | lit_val;
      IOBE_OP_OR_FILE: result = w_val | f_val;
      default:         result = DATA_ZERO;
    endcase
    // Zero is judged on the full eight bits; an increment of all ones wraps to zero.
    zero = (result == DATA_ZERO);
  end

endmodule : iobe_alu

//--- rtl/iobe_exec.sv
// Execution unit for increment, increment-skip, inclusive OR and jump instructions.
// Overview of operation
// - Increment-and-skip adds one to the file register, writes the chosen destination and leaves flags alone.
// - A zero increment-and-skip result squashes the next instruction, so it spends two instruction cycles.
// - Jump loads its 11-bit literal into program counter bits 10 to 0.
// - Jump copies high latch bits 4 and 3 into program counter bits 12 and 11.
// - Jump is unconditional, takes two instruction cycles and changes no flag.
// - OR-with-literal ORs the accumulator with the 8-bit literal into the accumulator and updates zero.
// - Plain increment adds one to the file register, stores at the destination and updates zero, with no skip.
// - OR-with-file ORs the accumulator with the file register into the destination and updates zero.
// - Destination bit 0 sends the result to the accumulator and bit 1 back to the file register.
`timescale 1ns/1ns
module iobe_exec
  import iobe_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  // Instruction from the decoder
  input  wire iobe_instr_t           INSTR,
  output logic                       READY,
  // Register file read port
  output logic      [ADDR_W-1:0]     FILE_RD_ADDR,
  input  wire logic [DATA_W-1:0]     FILE_RD_DATA,
  // Program counter high latch
  input  wire logic [DATA_W-1:0]     PC_HIGH_LATCH,
  // Register file write port
  output iobe_file_wr_t              FILE_WR,
  // Architectural state
  output logic      [DATA_W-1:0]     W,
  output logic                       ZERO,
  output logic      [PC_W-1:0]       PC
);

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  logic [1:0]        rst_sync_reg;
  logic              rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_reg <= SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], SYNC_FILL[0]};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================================================
  // Datapath
  // ==========================================================================
  iobe_state_t       state_reg;
  iobe_state_t       state_next;
  logic [DATA_W-1:0] alu_result;
  logic              alu_zero;
  logic              taken;

  iobe_alu u_alu (
    .op      (INSTR.op),
    .w_val   (state_reg.w),
    .f_val   (FILE_RD_DATA),
    .lit_val (INSTR.literal[DATA_W-1:0]),
    .result  (alu_result),
    .zero    (alu_zero)
  );

  // The squash cycle refuses a new instruction instead of buffering it; the decoder holds it.
  assign READY        = (state_reg.phase == IOBE_EXEC);
  assign taken        = INSTR.valid && READY;
  assign FILE_RD_ADDR = INSTR.file_addr;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    state_next            = state_reg;
    state_next.file_wr.we = 1'h0;
    case (state_reg.phase)
      IOBE_EXEC: begin
        if (taken) begin
          state_next.pc = state_reg.pc + PC_STEP;
          case (INSTR.op)
            IOBE_OP_INC_SKIP,
            IOBE_OP_INC,
            IOBE_OP_OR_FILE: begin
              if (INSTR.dest == DEST_F) begin
                state_next.file_wr = '{we: 1'h1, addr: INSTR.file_addr, data: alu_result};
              end else begin
                state_next.w = alu_result;
              end
              if (INSTR.op == IOBE_OP_INC_SKIP) begin
                // Flags stay as they are; only the skip looks at the result.
                if (alu_zero) begin
                  state_next.phase    = IOBE_FLUSH;
                  state_next.skip_adv = 1'h1;
                end
              end else begin
                state_next.zero = alu_zero;
              end
            end
            IOBE_OP_OR_LIT: begin
              state_next.w    = alu_result;
              state_next.zero = alu_zero;
            end
            IOBE_OP_JUMP: begin
              state_next.pc[PC_LIT_HI:0]    = INSTR.literal;
              state_next.pc[PC_W-1:LIT_W]   = PC_HIGH_LATCH[LATCH_HI:LATCH_LO];
              state_next.phase              = IOBE_FLUSH;
              state_next.skip_adv           = 1'h0;
            end
            default: begin
            end
          endcase
        end
      end
      IOBE_FLUSH: begin
        // The fetched instruction is dropped; a skip also steps over its address.
        state_next.phase = IOBE_EXEC;
        if (state_reg.skip_adv) begin
          state_next.pc = state_reg.pc + PC_STEP;
        end
        state_next.skip_adv = 1'h0;
      end
      default: begin
        state_next.phase = IOBE_EXEC;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.phase    <= IOBE_EXEC;
      state_reg.skip_adv <= 1'h0;
      state_reg.w        <= W_RESET;
      state_reg.zero     <= ZERO_RESET;
      state_reg.pc       <= PC_RESET;
      state_reg.file_wr  <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign FILE_WR = state_reg.file_wr;
  assign W       = state_reg.w;
  assign ZERO    = state_reg.zero;
  assign PC      = state_reg.pc;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  logic        take_skip;
  logic        take_inc;
  logic        take_jump;
  logic        take_orl;
  logic        take_orf;
  logic [10:0] lit_sig;
  logic [1:0]  latch_sig;

  assign take_skip = taken && (INSTR.op == IOBE_OP_INC_SKIP);
  assign take_inc  = taken && (INSTR.op == IOBE_OP_INC);
  assign take_jump = taken && (INSTR.op == IOBE_OP_JUMP);
  assign take_orl  = taken && (INSTR.op == IOBE_OP_OR_LIT);
  assign take_orf  = taken && (INSTR.op == IOBE_OP_OR_FILE);
  assign lit_sig   = INSTR.literal;
  assign latch_sig = PC_HIGH_LATCH[LATCH_HI:LATCH_LO];

  sequence squash_cycle;
    !READY ##1 READY;
  endsequence

  sequence file_written;
    FILE_WR.we && (FILE_WR.addr == $past(INSTR.file_addr));
  endsequence

  skip_keeps_flags_a: assert property (take_skip |=> (ZERO == $past(ZERO)))
    else $error("Increment-skip changed the zero flag.");

  skip_writes_file_a: assert property (take_skip && INSTR.dest == DEST_F
                                       |=> file_written ##0 (FILE_WR.data == $past(FILE_RD_DATA) + INC_STEP))
    else $error("Increment-skip did not write the incremented value.");

  skip_squash_a: assert property (take_skip && alu_zero |=> squash_cycle ##0 (PC == $past(PC, 2) + PC_STEP + PC_STEP))
    else $error("Zero increment-skip did not squash the next instruction.");

  no_skip_a: assert property (take_skip && !alu_zero |=> READY && PC == $past(PC) + PC_STEP)
    else $error("Nonzero increment-skip squashed an instruction.");

  jump_low_a: assert property (take_jump |=> PC[10:0] == $past(lit_sig))
    else $error("Jump loaded the wrong low program counter bits.");

  jump_high_a: assert property (take_jump |=> PC[12:11] == $past(latch_sig))
    else $error("Jump loaded the wrong high program counter bits.");

  jump_two_cycle_a: assert property (take_jump |=> (ZERO == $past(ZERO)) ##0 squash_cycle ##0 ($stable(PC) && $stable(ZERO)))
    else $error("Jump did not take two cycles or disturbed state.");

  or_literal_a: assert property (take_orl |=> W == ($past(W) | $past(lit_sig[7:0])) && ZERO == (W == 8'h00))
    else $error("OR-with-literal gave a wrong accumulator or zero flag.");

  inc_file_a: assert property (take_inc |=> READY && ZERO == (&$past(FILE_RD_DATA)))
    else $error("Plain increment skipped or left the zero flag wrong.");

  or_file_a: assert property (take_orf && INSTR.dest == DEST_F |=> file_written
                              ##0 (FILE_WR.data == ($past(W) | $past(FILE_RD_DATA)))
                              ##0 (ZERO == (FILE_WR.data == DATA_ZERO)))
    else $error("OR-with-file did not store its result or zero flag.");

  dest_w_a: assert property ((take_inc || take_orf) && INSTR.dest == DEST_W
                             |=> !FILE_WR.we && W == ($past(take_inc) ? ($past(FILE_RD_DATA) + INC_STEP)
                                                                      : ($past(W) | $past(FILE_RD_DATA))))
    else $error("Destination bit 0 did not route the result to the accumulator.");

  zero_with_write_a: assert property ((take_inc || take_orf) && INSTR.dest == DEST_F
                                      |=> FILE_WR.we && ZERO == (FILE_WR.data == 8'h00))
    else $error("Zero flag and result write were not updated together.");

endmodule : iobe_exec

//--- tb/iobe_regfile_model.sv
// Register file model that sits on the far side of the execution block.
`timescale 1ns/1ns
module iobe_regfile_model
  import iobe_pkg::*;
(
  // Clock
  input  wire logic              CLK,
  // Read and write ports
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  input  wire iobe_file_wr_t     wr
);
  // ====================
  // Storage
  // ====================
  logic [DATA_W-1:0] mem [128];

  // A recognisable fill, so that a read of an untouched register is not mistaken for zero.
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'hA5;
    end
  end

  assign rd_data = mem[rd_addr];

  always @(posedge CLK) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end
endmodule : iobe_regfile_model

//--- tb/tb_top.sv
// Self-checking testbench for the increment, inclusive-OR and jump execution block.
`timescale 1ns/1ns
module tb_top import iobe_pkg::*;;
  typedef struct packed {
    iobe_op_t         op;
    logic             dest;
    logic [LIT_W-1:0] lit;
    logic [7:0]       fval;
    logic [7:0]       res;
    logic             z;
  } iobe_row_t;

  logic              CLK;
  logic              RST_B;
  logic              READY;
  logic              ZERO;
  iobe_instr_t       INSTR;
  logic [ADDR_W-1:0] FILE_RD_ADDR;
  logic [DATA_W-1:0] FILE_RD_DATA;
  logic [DATA_W-1:0] PC_HIGH_LATCH;
  logic [DATA_W-1:0] W;
  iobe_file_wr_t     FILE_WR;
  logic [PC_W-1:0]   PC;
  logic [7:0]        ew;
  logic [PC_W-1:0]   epc;
  iobe_row_t         rows [14];
  int                n_errors;
  int                checks_done;

  iobe_exec u_iobe_exec (.CLK(CLK), .RST_B(RST_B), .INSTR(INSTR), .READY(READY), .FILE_RD_ADDR(FILE_RD_ADDR),
    .FILE_RD_DATA(FILE_RD_DATA), .PC_HIGH_LATCH(PC_HIGH_LATCH), .FILE_WR(FILE_WR), .W(W), .ZERO(ZERO), .PC(PC));
  iobe_regfile_model u_iobe_regfile_model (.CLK(CLK), .rd_addr(FILE_RD_ADDR), .rd_data(FILE_RD_DATA),
    .wr(FILE_WR));

  // ====================
  // Checking and closing
  // ====================
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("Errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // ====================
  // One instruction, issued back to back with the previous one
  // ====================
  task automatic run(input iobe_row_t r);
    logic fo;
    logic fl;
    fo = r.op inside {IOBE_OP_INC, IOBE_OP_INC_SKIP, IOBE_OP_OR_FILE};
    fl = (r.op == IOBE_OP_JUMP) || (r.op == IOBE_OP_INC_SKIP && r.res == DATA_ZERO);
    u_iobe_regfile_model.mem[r.lit[6:0]] = r.fval;
    INSTR = '{valid: 1'b1, op: r.op, file_addr: r.lit[6:0], dest: r.dest, literal: r.lit};
    PC_HIGH_LATCH = r.fval;
    chk("ready", 1, READY);
    chk("rd addr", r.lit[6:0], FILE_RD_ADDR);
    @(posedge CLK);
    #1;
    epc = (r.op == IOBE_OP_JUMP) ? {r.fval[LATCH_HI:LATCH_LO], r.lit} : epc + PC_STEP;
    if (r.op == IOBE_OP_OR_LIT || (fo && r.dest == DEST_W)) ew = r.res;
    chk("w", ew, W);
    chk("zero", r.z, ZERO);
    chk("pc", epc, PC);
    chk("we", fo && r.dest, FILE_WR.we);
    if (fo && r.dest) chk("wr", {r.lit[6:0], r.res}, {FILE_WR.addr, FILE_WR.data});
    chk("ready after", !fl, READY);
    if (fl) begin
      INSTR.valid = 1'b0;
      @(posedge CLK);
      #1;
      if (r.op != IOBE_OP_JUMP) epc = epc + PC_STEP;
      chk("flush pc", epc, PC);
      chk("flush ready", 1, READY);
    end
  endtask : run

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    RST_B = 1'b0;
    INSTR = '0;
    PC_HIGH_LATCH = 8'h00;
    ew = W_RESET;
    epc = PC_RESET;
    rows = '{'{IOBE_OP_OR_LIT, 1'h0, 11'h000, 8'h00, 8'h00, 1'h1}, '{IOBE_OP_OR_LIT, 1'h0, 11'h7A5, 8'h00, 8'hA5, 1'h0},
      '{IOBE_OP_INC, 1'h0, 11'h07F, 8'hFF, 8'h00, 1'h1}, '{IOBE_OP_INC, 1'h1, 11'h001, 8'h7F, 8'h80, 1'h0},
      '{IOBE_OP_OR_FILE, 1'h1, 11'h040, 8'h3C, 8'h3C, 1'h0}, '{IOBE_OP_OR_FILE, 1'h0, 11'h002, 8'h00, 8'h00, 1'h1},
      '{IOBE_OP_INC_SKIP, 1'h0, 11'h003, 8'h10, 8'h11, 1'h1}, '{IOBE_OP_OR_FILE, 1'h1, 11'h004, 8'h80, 8'h91, 1'h0},
      '{IOBE_OP_INC_SKIP, 1'h1, 11'h07F, 8'hFF, 8'h00, 1'h0}, '{IOBE_OP_INC_SKIP, 1'h0, 11'h006, 8'hFF, 8'h00, 1'h0},
      '{IOBE_OP_JUMP, 1'h0, 11'h7FF, 8'h18, 8'h00, 1'h0}, '{IOBE_OP_OR_LIT, 1'h0, 11'h000, 8'h00, 8'h00, 1'h1},
      '{IOBE_OP_JUMP, 1'h0, 11'h000, 8'hE7, 8'h00, 1'h1}, '{IOBE_OP_NONE, 1'h0, 11'h000, 8'h00, 8'h00, 1'h1}};
    repeat (16) @(posedge CLK);
    #1;
    RST_B = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk("reset state", {W_RESET, 7'h00, ZERO_RESET}, {W, 7'h00, ZERO});
    foreach (rows[i]) begin
      run(rows[i]);
    end
    // The decoder keeps the squashed instruction up; it must only run once the flush is over.
    u_iobe_regfile_model.mem[7'h05] = 8'hFF;
    INSTR = '{valid: 1'b1, op: IOBE_OP_INC_SKIP, file_addr: 7'h05, dest: DEST_F, literal: 11'h005};
    @(posedge CLK);
    #1;
    INSTR = '{valid: 1'b1, op: IOBE_OP_OR_LIT, file_addr: 7'h00, dest: DEST_W, literal: 11'h0C3};
    @(posedge CLK);
    #1;
    chk("held w", ew, W);
    @(posedge CLK);
    #1;
    INSTR.valid = 1'b0;
    chk("late w", ew | 8'hC3, W);
    chk("late zero", 1'h0, ZERO);
    // A second reset in mid-run clears the state at once, without a clock edge.
    RST_B = 1'b0;
    #2;
    chk("mid reset pc", PC_RESET, PC);
    chk("mid reset", {W_RESET, ZERO_RESET, 1'h0}, {W, ZERO, FILE_WR.we});
    chk("mid ready", 1, READY);
    repeat (2) @(posedge CLK);
    #1;
    RST_B = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    ew = W_RESET;
    epc = PC_RESET;
    run(iobe_row_t'{IOBE_OP_OR_LIT, 1'h0, 11'h05A, 8'h00, 8'h5A, 1'h0});
    conclude();
  end
endmodule : tb_top
